//--- rtl/timer8_core.sv
// Overview of operation
// - Channel A force ignored in PWM modes.
// - Force strobe makes immediate waveform compare match.
// - Force never sets flags nor clears counter.
// - Force strobe bits always read as zero.
// - Clock select: stop, or divide by 1..1024.
// - Codes 110/111 count external falling/rising edges.
// - External pin counts even when driven as output.
// - Channel B interrupt: enable, global, flag.
// - Channel A interrupt: enable, global, flag.
// - Overflow interrupt: enable, global, flag.
// - Sync mode holds both prescaler reset bits.
// - Sync mode cleared clears both reset bits; in async mode the async bit waits for async reset done.
// - Async reset bit resets third timer prescaler.
// - Shared reset bit clears shared prescaler.
// - Counter read/write; write blocks next match.
// - Compare registers continuously matched against counter.
// - Low registers reachable at offset minus 0x20.
// - Mode bit plus external bits select waveform.
// - Non-PWM output modes: off, toggle, clear, set.
// - Flags cleared by vector or written one.
module timer8_core
    import timer8_pkg::*;
(
    input  wire logic       clk_in,
    input  wire logic       rstn_in,
    input  wire io_req_t    bus_in,
    output logic [7:0]      rdata_out,
    input  wire logic [1:0] wave_mode_lo_in,
    input  wire logic [1:0] out_mode_a_in,
    input  wire logic [1:0] out_mode_b_in,
    input  wire logic       gie_in,
    input  wire logic [2:0] flag_clr_in,
    input  wire logic       ext_count_pin_in,
    input  wire logic       async_mode_in,
    input  wire logic       async_reset_done_in,
    output logic            wave_out_a_out,
    output logic            wave_out_b_out,
    output logic [2:0]      flags_out,
    output logic [2:0]      irq_out,
    output logic            shared_prescale_reset_out,
    output logic            async_prescale_reset_out
);

    function automatic logic reg_hit(input io_req_t r, input logic [7:0] ofs);
        logic [7:0] io_ofs;
        io_ofs = 8'(r.addr + IO_SPACE_BASE);
        if (r.io_space)
            return (r.addr <= IO_SPACE_LAST) && (io_ofs == ofs);
        return r.addr == ofs;
    endfunction : reg_hit

    function automatic logic is_non_pwm(input wave_mode_t m);
        return (m == WM_NORMAL) || (m == WM_CTC);
    endfunction : is_non_pwm

    // One compare or bottom event applied to a waveform output.
    function automatic logic wave_step(input logic cur, input logic [1:0] om, input logic match,
                                       input logic bottom, input logic fast, input logic pc,
                                       input logic up, input logic tog_ok);
        logic res;
        res = cur;
        if (match) begin
            if (om == 2'b01 && (tog_ok || (!fast && !pc)))
                res = ~cur;
            else if (om == 2'b10)
                res = pc ? !up : 1'b0;
            else if (om == 2'b11)
                res = pc ? up : 1'b1;
        end
        if (fast && bottom) begin
            if (om == 2'b10)
                res = 1'b1;
            else if (om == 2'b11)
                res = 1'b0;
        end
        return res;
    endfunction : wave_step

    logic             sync_hold_mode;
    logic             async_prescale_clr;
    logic             shared_prescale_clr;
    logic             wave_mode_hi;
    clk_sel_t         clk_sel;
    logic [7:0]       count_value;
    logic [7:0]       cmp_a_value;
    logic [7:0]       cmp_b_value;
    logic [2:0]       irq_mask;
    logic [9:0]       prescaler;
    logic             pin_prev;
    logic             match_block;
    count_dir_t       dir;

    logic             next_sync_hold_mode;
    logic             next_async_prescale_clr;
    logic             next_shared_prescale_clr;
    logic [7:0]       next_count_value;
    logic [9:0]       next_prescaler;
    logic             next_match_block;
    count_dir_t       next_dir;
    logic [2:0]       next_flags;
    logic [2:0]       next_irq;
    logic [7:0]       next_rdata;
    logic             next_wave_a;
    logic             next_wave_b;

    wire logic wr_sync  = bus_in.wr && reg_hit(bus_in, OFS_SYNC_CTRL);
    wire logic wr_ctrlb = bus_in.wr && reg_hit(bus_in, OFS_CTRL_B);
    wire logic wr_count = bus_in.wr && reg_hit(bus_in, OFS_COUNT);
    wire logic wr_cmp_a = bus_in.wr && reg_hit(bus_in, OFS_CMP_A);
    wire logic wr_cmp_b = bus_in.wr && reg_hit(bus_in, OFS_CMP_B);
    wire logic wr_mask  = bus_in.wr && reg_hit(bus_in, OFS_INT_MASK);

    // Mode decoding.
    wire wave_mode_t wm        = wave_mode_t'({wave_mode_hi, wave_mode_lo_in});
    wire wave_mode_t wm_new    = wave_mode_t'({bus_in.wdata[CTRLB_WAVE_HI], wave_mode_lo_in});
    wire logic       mode_pc   = (wm == WM_PC_FF) || (wm == WM_PC_A);
    wire logic       mode_fast = (wm == WM_FAST_FF) || (wm == WM_FAST_A);
    wire logic       top_is_a  = (wm == WM_CTC) || (wm == WM_PC_A) || (wm == WM_FAST_A);
    wire logic [7:0] top_value = top_is_a ? cmp_a_value : COUNT_MAX;
    wire logic       at_top    = count_value == top_value;
    wire logic       at_bottom = count_value == COUNT_BOTTOM;

    // Timer clock selection; the pin input is taken as synchronous.
    wire logic ext_rise = ext_count_pin_in && !pin_prev;
    wire logic ext_fall = !ext_count_pin_in && pin_prev;
    wire logic int_run  = !shared_prescale_clr;
    wire logic tick =
        (clk_sel == CLK_DIV1)     ? int_run :
        (clk_sel == CLK_DIV8)     ? int_run && ((prescaler & TAP_DIV8) == TAP_DIV8) :
        (clk_sel == CLK_DIV64)    ? int_run && ((prescaler & TAP_DIV64) == TAP_DIV64) :
        (clk_sel == CLK_DIV256)   ? int_run && ((prescaler & TAP_DIV256) == TAP_DIV256) :
        (clk_sel == CLK_DIV1024)  ? int_run && ((prescaler & TAP_DIV1024) == TAP_DIV1024) :
        (clk_sel == CLK_EXT_FALL) ? ext_fall :
        (clk_sel == CLK_EXT_RISE) ? ext_rise : 1'b0;

    // Counting sequence.
    wire logic [7:0] count_inc  = 8'(count_value + COUNT_ONE);
    wire logic [7:0] count_dec  = 8'(count_value - COUNT_ONE);
    wire logic       pc_turn_dn = (dir == DIR_UP) && at_top;
    wire logic       pc_turn_up = (dir == DIR_DOWN) && at_bottom;
    wire logic       pc_go_up   = pc_turn_up || ((dir == DIR_UP) && !pc_turn_dn);
    wire logic [7:0] pc_step    = pc_go_up ? count_inc : count_dec;
    wire logic [7:0] lin_step   = at_top ? COUNT_BOTTOM : count_inc;
    wire logic [7:0] count_step = mode_pc ? pc_step : lin_step;

    // Compare and overflow events on a timer clock.
    wire logic hit_a    = tick && !match_block && (count_value == cmp_a_value);
    wire logic hit_b    = tick && !match_block && (count_value == cmp_b_value);
    wire logic ovf_at   = mode_pc ? pc_turn_up : ((wm == WM_FAST_A) ? at_top : (count_value == COUNT_MAX));
    wire logic ovf_hit  = tick && ovf_at;
    wire logic fast_bot = tick && mode_fast && at_top;

    // Forced compares only act in non-PWM modes and touch the waveform only.
    wire logic force_a = wr_ctrlb && bus_in.wdata[CTRLB_FORCE_A] && is_non_pwm(wm_new);
    wire logic force_b = wr_ctrlb && bus_in.wdata[CTRLB_FORCE_B] && is_non_pwm(wm_new);
    wire logic [2:0] flag_set = {hit_b, hit_a, ovf_hit};

    assign next_count_value = wr_count ? bus_in.wdata : (tick ? count_step : count_value);
    assign next_match_block = wr_count ? 1'b1 : (tick ? 1'b0 : match_block);
    assign next_dir         = !mode_pc ? DIR_UP : (tick ? (pc_go_up ? DIR_UP : DIR_DOWN) : dir);
    assign next_prescaler   = shared_prescale_clr ? PRESC_ZERO : 10'(prescaler + PRESC_ONE);
    assign next_flags       = flag_set | (flags_out & ~flag_clr_in);
    assign next_irq         = flags_out & irq_mask & {3{gie_in}};

    assign next_wave_a = wave_step(wave_out_a_out, out_mode_a_in, hit_a || force_a, fast_bot,
                                   mode_fast, mode_pc, dir == DIR_UP, wave_mode_hi);
    assign next_wave_b = wave_step(wave_out_b_out, out_mode_b_in, hit_b || force_b, fast_bot,
                                   mode_fast, mode_pc, dir == DIR_UP, 1'b0);

    // Prescaler reset bits: kept while sync mode is on, else cleared at once; in async mode the async bit waits for async reset done.
    assign next_sync_hold_mode      = wr_sync ? bus_in.wdata[SYNC_HOLD_BIT] : sync_hold_mode;
    assign next_shared_prescale_clr = wr_sync ? bus_in.wdata[SHARED_CLR_BIT] :
                                      (shared_prescale_clr && sync_hold_mode);
    assign next_async_prescale_clr  = wr_sync ? bus_in.wdata[ASYNC_CLR_BIT] :
                                      (async_prescale_clr && (sync_hold_mode ||
                                       (async_mode_in && !async_reset_done_in)));

    wire logic [7:0] rd_sync  = {sync_hold_mode, 5'b00000, async_prescale_clr, shared_prescale_clr};
    wire logic [7:0] rd_ctrlb = {2'b00, 2'b00, wave_mode_hi, clk_sel};
    wire logic [7:0] rd_mask  = {5'b00000, irq_mask};
    assign next_rdata = !bus_in.rd                       ? REG_RESET :
                        reg_hit(bus_in, OFS_SYNC_CTRL)   ? rd_sync :
                        reg_hit(bus_in, OFS_CTRL_B)      ? rd_ctrlb :
                        reg_hit(bus_in, OFS_COUNT)       ? count_value :
                        reg_hit(bus_in, OFS_CMP_A)       ? cmp_a_value :
                        reg_hit(bus_in, OFS_CMP_B)       ? cmp_b_value :
                        reg_hit(bus_in, OFS_INT_MASK)    ? rd_mask : REG_RESET;

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            sync_hold_mode      <= 1'b0;
            async_prescale_clr  <= 1'b0;
            shared_prescale_clr <= 1'b0;
            wave_mode_hi        <= 1'b0;
            clk_sel             <= CLK_STOP;
            irq_mask            <= 3'h0;
            cmp_a_value         <= REG_RESET;
            cmp_b_value         <= REG_RESET;
        end else begin
            sync_hold_mode      <= next_sync_hold_mode;
            async_prescale_clr  <= next_async_prescale_clr;
            shared_prescale_clr <= next_shared_prescale_clr;
            if (wr_ctrlb) begin
                wave_mode_hi <= bus_in.wdata[CTRLB_WAVE_HI];
                clk_sel      <= clk_sel_t'(bus_in.wdata[2:0]);
            end
            if (wr_mask)
                irq_mask <= bus_in.wdata[2:0];
            if (wr_cmp_a)
                cmp_a_value <= bus_in.wdata;
            if (wr_cmp_b)
                cmp_b_value <= bus_in.wdata;
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            count_value <= REG_RESET;
            match_block <= 1'b0;
            dir         <= DIR_UP;
            prescaler   <= PRESC_ZERO;
            pin_prev    <= 1'b0;
        end else begin
            count_value <= next_count_value;
            match_block <= next_match_block;
            dir         <= next_dir;
            prescaler   <= next_prescaler;
            pin_prev    <= ext_count_pin_in;
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rdata_out                 <= REG_RESET;
            wave_out_a_out            <= 1'b0;
            wave_out_b_out            <= 1'b0;
            flags_out                 <= 3'h0;
            irq_out                   <= 3'h0;
            shared_prescale_reset_out <= 1'b0;
            async_prescale_reset_out  <= 1'b0;
        end else begin
            rdata_out                 <= next_rdata;
            wave_out_a_out            <= next_wave_a;
            wave_out_b_out            <= next_wave_b;
            flags_out                 <= next_flags;
            irq_out                   <= next_irq;
            shared_prescale_reset_out <= next_shared_prescale_clr;
            async_prescale_reset_out  <= next_async_prescale_clr;
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rstn_in);

    wire logic quiet_bus = !bus_in.wr;

    property p_force_a_pwm_ignored;
        wr_ctrlb && bus_in.wdata[CTRLB_FORCE_A] && !is_non_pwm(wm_new) && clk_sel == CLK_STOP
            |=> $stable(wave_out_a_out);
    endproperty
    a_force_a_pwm_ignored: assert property (p_force_a_pwm_ignored) else $error("force A acted in PWM mode");

    property p_force_sets_out;
        wr_ctrlb && bus_in.wdata[CTRLB_FORCE_A] && is_non_pwm(wm_new) && out_mode_a_in == 2'b11
            |=> wave_out_a_out;
    endproperty
    a_force_sets_out: assert property (p_force_sets_out) else $error("force A did not set output");

    property p_force_no_side_effect;
        wr_ctrlb && (bus_in.wdata[CTRLB_FORCE_A] || bus_in.wdata[CTRLB_FORCE_B]) && clk_sel == CLK_STOP
            |=> $stable(count_value) && ((flags_out & ~$past(flags_out)) == 3'h0);
    endproperty
    a_force_no_side_effect: assert property (p_force_no_side_effect) else $error("force changed count or flags");

    property p_force_reads_zero;
        bus_in.rd && reg_hit(bus_in, OFS_CTRL_B) |=> rdata_out[7:6] == 2'b00 && rdata_out[5:4] == 2'b00;
    endproperty
    a_force_reads_zero: assert property (p_force_reads_zero) else $error("control read shows force bits");

    property p_stopped_holds;
        clk_sel == CLK_STOP && !wr_count |=> count_value == $past(count_value);
    endproperty
    a_stopped_holds: assert property (p_stopped_holds) else $error("counter moved while stopped");

    property p_div1_counts;
        clk_sel == CLK_DIV1 && wm == WM_NORMAL && !shared_prescale_clr && !wr_count
            |=> count_value == 8'($past(count_value) + COUNT_ONE);
    endproperty
    a_div1_counts: assert property (p_div1_counts) else $error("divide-by-1 did not advance");

    property p_ext_rise_counts;
        clk_sel == CLK_EXT_RISE && wm == WM_NORMAL && ext_count_pin_in && !pin_prev && !wr_count
            |=> count_value == 8'($past(count_value) + COUNT_ONE);
    endproperty
    a_ext_rise_counts: assert property (p_ext_rise_counts) else $error("rising pin edge not counted");

    property p_irq_b;
        (flags_out[IRQ_CMP_B] && irq_mask[IRQ_CMP_B] && gie_in)[*2] |-> irq_out[IRQ_CMP_B];
    endproperty
    a_irq_b: assert property (p_irq_b) else $error("compare B interrupt missing");

    property p_irq_a_off;
        !gie_in |=> !irq_out[IRQ_CMP_A] && !irq_out[IRQ_OVF];
    endproperty
    a_irq_a_off: assert property (p_irq_a_off) else $error("interrupt raised without global enable");

    property p_sync_holds;
        sync_hold_mode && !wr_sync |=> $stable({shared_prescale_clr, async_prescale_clr});
    endproperty
    a_sync_holds: assert property (p_sync_holds) else $error("reset bits moved in sync mode");

    property p_sync_release;
        wr_sync && !bus_in.wdata[SYNC_HOLD_BIT] ##1 quiet_bus |=> !shared_prescale_clr && !shared_prescale_reset_out;
    endproperty
    a_sync_release: assert property (p_sync_release) else $error("shared reset bit not cleared");

    property p_async_clears;
        async_prescale_clr && !sync_hold_mode && !async_mode_in && !wr_sync |=> !async_prescale_clr;
    endproperty
    a_async_clears: assert property (p_async_clears) else $error("async reset bit not cleared");

    property p_write_blocks_match;
        wr_count && bus_in.wdata == cmp_a_value && clk_sel == CLK_DIV1 && !shared_prescale_clr
            && count_value != cmp_a_value && !flags_out[IRQ_CMP_A] && !wr_cmp_a
            ##1 quiet_bus |=> !flags_out[IRQ_CMP_A];
    endproperty
    a_write_blocks_match: assert property (p_write_blocks_match) else $error("match not blocked after write");

    property p_match_sets_flag;
        hit_b |=> flags_out[IRQ_CMP_B];
    endproperty
    a_match_sets_flag: assert property (p_match_sets_flag) else $error("compare B flag not set");

    property p_io_alias;
        bus_in.rd && bus_in.io_space && bus_in.addr == 8'h27 |=> rdata_out == $past(cmp_a_value);
    endproperty
    a_io_alias: assert property (p_io_alias) else $error("short I/O address read wrong");

    property p_ctc_wraps;
        wm == WM_CTC && tick && at_top && !wr_count |=> count_value == COUNT_BOTTOM;
    endproperty
    a_ctc_wraps: assert property (p_ctc_wraps) else $error("clear-on-compare did not wrap");

    property p_clear_b;
        is_non_pwm(wm) && out_mode_b_in == 2'b10 && hit_b |=> !wave_out_b_out;
    endproperty
    a_clear_b: assert property (p_clear_b) else $error("output B not cleared on match");

    property p_flag_clear;
        flag_clr_in[IRQ_OVF] && !ovf_hit |=> !flags_out[IRQ_OVF];
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("overflow flag not cleared");

    c_force_toggle: cover property (force_a && out_mode_a_in == 2'b01);
    c_overflow:     cover property (ovf_hit && irq_mask[IRQ_OVF] && gie_in);
    c_ext_fall:     cover property (clk_sel == CLK_EXT_FALL && tick);
    c_sync_cycle:   cover property (sync_hold_mode && shared_prescale_clr ##1 wr_sync);

endmodule : timer8_core

//--- rtl/timer8_pkg.sv
package timer8_pkg;

    // Data-space offsets of the registers.
    localparam logic [7:0] OFS_SYNC_CTRL   = 8'h43;
    localparam logic [7:0] OFS_CTRL_B      = 8'h45;
    localparam logic [7:0] OFS_COUNT       = 8'h46;
    localparam logic [7:0] OFS_CMP_A       = 8'h47;
    localparam logic [7:0] OFS_CMP_B       = 8'h48;
    localparam logic [7:0] OFS_INT_MASK    = 8'h6E;

    // Short I/O addresses are the data-space offset minus this base.
    localparam logic [7:0] IO_SPACE_BASE   = 8'h20;
    localparam logic [7:0] IO_SPACE_LAST   = 8'h3F;

    localparam logic [7:0] REG_RESET       = 8'h00;
    localparam logic [7:0] COUNT_MAX       = 8'hFF;
    localparam logic [7:0] COUNT_BOTTOM    = 8'h00;
    localparam logic [7:0] COUNT_ONE       = 8'h01;

    // Field positions.
    localparam int CTRLB_FORCE_A           = 7;
    localparam int CTRLB_FORCE_B           = 6;
    localparam int CTRLB_WAVE_HI           = 3;
    localparam int SYNC_HOLD_BIT           = 7;
    localparam int ASYNC_CLR_BIT           = 1;
    localparam int SHARED_CLR_BIT          = 0;
    localparam int IRQ_CMP_B               = 2;
    localparam int IRQ_CMP_A               = 1;
    localparam int IRQ_OVF                 = 0;

    // Prescaler taps: a tick is issued when all masked bits are one.
    localparam logic [9:0] TAP_DIV8        = 10'h007;
    localparam logic [9:0] TAP_DIV64       = 10'h03F;
    localparam logic [9:0] TAP_DIV256      = 10'h0FF;
    localparam logic [9:0] TAP_DIV1024     = 10'h3FF;
    localparam logic [9:0] PRESC_ZERO      = 10'h000;
    localparam logic [9:0] PRESC_ONE       = 10'h001;

    typedef enum logic [2:0] {
        CLK_STOP     = 3'b000,
        CLK_DIV1     = 3'b001,
        CLK_DIV8     = 3'b010,
        CLK_DIV64    = 3'b011,
        CLK_DIV256   = 3'b100,
        CLK_DIV1024  = 3'b101,
        CLK_EXT_FALL = 3'b110,
        CLK_EXT_RISE = 3'b111
    } clk_sel_t;

    typedef enum logic [2:0] {
        WM_NORMAL    = 3'b000,
        WM_PC_FF     = 3'b001,
        WM_CTC       = 3'b010,
        WM_FAST_FF   = 3'b011,
        WM_RSVD4     = 3'b100,
        WM_PC_A      = 3'b101,
        WM_RSVD6     = 3'b110,
        WM_FAST_A    = 3'b111
    } wave_mode_t;

    typedef enum logic {
        DIR_UP       = 1'b0,
        DIR_DOWN     = 1'b1
    } count_dir_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic       io_space;
        logic [7:0] addr;
        logic [7:0] wdata;
    } io_req_t;

endpackage : timer8_pkg

//--- tb/cpu_model.sv
module cpu_model
    import timer8_pkg::*;
(
    input  wire logic       clk_in,
    input  wire logic [7:0] rdata_in,
    output io_req_t         bus_out
);
    timeunit 1ns;
    timeprecision 1ps;

    initial bus_out = '0;

    // One request per access, launched on a falling edge and taken at the next rising edge.
    task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d, input logic io,
                          output logic [7:0] q);
        @(negedge clk_in);
        bus_out = '{wr: w, rd: !w, io_space: io, addr: a, wdata: d};
        @(negedge clk_in);
        bus_out = '0;
        q = rdata_in;
    endtask : access
endmodule : cpu_model

//--- tb/timer8_control_and_prescaler_sync_tb_top.sv
module timer8_control_and_prescaler_sync_tb_top
    import timer8_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk_in = 0, rstn_in = 0, gie = 0, pin = 0, amode = 0, adone = 0;
    logic [1:0] wml = 0, oma = 0, omb = 0;
    logic [2:0] fclr = 0, flags, irq;
    logic [7:0] rdata, q, r, a;
    logic       wa, wb, sps, aps;
    io_req_t    bus;
    int         fail_count = 0, checks_done = 0, cyc = 0;
    int         sh[6] = '{0, 0, 3, 6, 8, 10};
    logic [7:0] ofs[6] = '{8'h43, 8'h45, 8'h46, 8'h47, 8'h48, 8'h6E};

    always #2.5 clk_in = ~clk_in;

    cpu_model cpu (.clk_in(clk_in), .rdata_in(rdata), .bus_out(bus));

    timer8_core dut (.clk_in(clk_in), .rstn_in(rstn_in), .bus_in(bus), .rdata_out(rdata),
        .wave_mode_lo_in(wml), .out_mode_a_in(oma), .out_mode_b_in(omb), .gie_in(gie), .flag_clr_in(fclr),
        .ext_count_pin_in(pin), .async_mode_in(amode), .async_reset_done_in(adone), .wave_out_a_out(wa),
        .wave_out_b_out(wb), .flags_out(flags), .irq_out(irq), .shared_prescale_reset_out(sps),
        .async_prescale_reset_out(aps));

    task automatic cmp8(input string n, input logic [7:0] e, input logic [7:0] s);
        checks_done++;
        if (s !== e) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask : cmp8

    task automatic wr(input logic [7:0] ad, input logic [7:0] d, input logic io = 0);
        cpu.access(1'b1, ad, d, io, q);
    endtask : wr

    task automatic rd(input logic [7:0] ad, input logic io = 0);
        cpu.access(1'b0, ad, 8'h00, io, q);
    endtask : rd

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : tally_and_finish

    always @(posedge clk_in) begin
        cyc++;
        if (cyc > 30000) begin
            fail_count++;
            tally_and_finish();
        end
    end

    initial begin
        void'($urandom(32'h4B17A848));
        repeat (12) @(posedge clk_in);
        @(negedge clk_in) rstn_in = 1;
        foreach (ofs[i]) begin
            rd(ofs[i]);
            cmp8("reset value", 8'h00, q);
        end
        rd(8'h44);
        cmp8("unmapped", 8'h00, q);
        rd(8'h4E, 1'b1);
        cmp8("io unmapped", 8'h00, q);
        // Counter is stopped here, so writing it cannot lose a match.
        for (int i = 0; i < 6; i++) begin
            r = 8'($urandom);
            a = 8'h46 + 8'(i % 3);
            wr(i > 2 ? a - IO_SPACE_BASE : a, r, i > 2);
            rd(i > 2 ? a : a - IO_SPACE_BASE, i <= 2);
            cmp8("rw data/io", r, q);
        end
        wr(OFS_CTRL_B, 8'hF8);
        rd(OFS_CTRL_B);
        cmp8("ctrl_b", 8'h08, q);
        wr(OFS_CTRL_B, 8'h00);
        wr(OFS_INT_MASK, 8'hFF);
        rd(OFS_INT_MASK);
        cmp8("mask", 8'h07, q);
        wr(OFS_SYNC_CTRL, 8'hFF);
        repeat (3) @(negedge clk_in);
        rd(OFS_SYNC_CTRL);
        cmp8("sync hold", 8'h83, q);
        cmp8("shared reset", 8'h01, {7'h0, sps});
        wr(OFS_SYNC_CTRL, 8'h00);
        rd(OFS_SYNC_CTRL);
        cmp8("sync release", 8'h00, {6'h0, aps, sps});
        amode = 1;
        wr(OFS_SYNC_CTRL, 8'h02);
        rd(OFS_SYNC_CTRL);
        cmp8("async pending", 8'h02, q);
        adone = 1;
        repeat (2) @(negedge clk_in);
        rd(OFS_SYNC_CTRL);
        cmp8("async done", 8'h00, q);
        for (int c = 0; c <= 5; c++) begin
            wr(OFS_CTRL_B, 8'(c));
            rd(OFS_COUNT);
            r = q;
            repeat ((8 << sh[c]) - 2) @(negedge clk_in);
            rd(OFS_COUNT);
            cmp8("count rate", r + (c > 0 ? 8'h08 : 8'h00), q);
        end
        for (int c = 6; c <= 7; c++) begin
            wr(OFS_CTRL_B, 8'(c));
            rd(OFS_COUNT);
            r = q;
            repeat (5) begin
                repeat (3) @(negedge clk_in);
                pin = ~pin;
            end
            repeat (3) @(negedge clk_in);
            rd(OFS_COUNT);
            cmp8("ext edges", r + 8'h02, q);
        end
        wr(OFS_CTRL_B, 8'h00);
        fclr = 3'h7;
        @(negedge clk_in) fclr = 3'h0;
        wr(OFS_COUNT, 8'h70);
        wr(OFS_CMP_A, 8'h80);
        wr(OFS_CMP_B, 8'h90);
        gie = 1;
        omb = 2'h3;
        wr(OFS_CTRL_B, 8'h01);
        repeat (20) @(negedge clk_in);
        cmp8("flags a", 8'h02, {5'h0, flags});
        cmp8("irq a", 8'h02, {5'h0, irq});
        repeat (20) @(negedge clk_in);
        cmp8("irq b", 8'h06, {5'h0, irq});
        cmp8("wave b set", 8'h01, {7'h0, wb});
        repeat (110) @(negedge clk_in);
        cmp8("irq ovf", 8'h07, {5'h0, irq});
        gie = 0;
        repeat (3) @(negedge clk_in);
        cmp8("irq masked", 8'h00, {5'h0, irq});
        // Write the counter onto compare A while it runs: the next match must be lost.
        omb = 2'h2;
        fclr = 3'h7;
        @(negedge clk_in) fclr = 3'h0;
        wr(OFS_COUNT, 8'h80);
        repeat (4) @(negedge clk_in);
        cmp8("match blocked", 8'h00, {5'h0, flags});
        repeat (16) @(negedge clk_in);
        cmp8("wave b clear", 8'h00, {7'h0, wb});
        wr(OFS_CTRL_B, 8'h00);
        fclr = 3'h7;
        @(negedge clk_in) fclr = 3'h0;
        @(negedge clk_in);
        cmp8("flags clear", 8'h00, {5'h0, flags});
        oma = 2'h3;
        omb = 2'h3;
        wr(OFS_CTRL_B, 8'hC0);
        @(negedge clk_in);
        cmp8("force set", 8'h01, {7'h0, wa});
        cmp8("force b set", 8'h01, {7'h0, wb});
        cmp8("force no flag", 8'h00, {5'h0, flags});
        oma = 2'h1;
        wr(OFS_CTRL_B, 8'h80);
        @(negedge clk_in);
        cmp8("force toggle", 8'h00, {7'h0, wa});
        wml = 2'h3;
        wr(OFS_CTRL_B, 8'h80);
        @(negedge clk_in);
        cmp8("force in pwm", 8'h00, {7'h0, wa});
        wr(OFS_CTRL_B, 8'h00);
        // Clear-on-compare with top 5 counts 0..5, so 21 ticks leave 3.
        wml = 2'h2;
        wr(OFS_CMP_A, 8'h05);
        wr(OFS_COUNT, 8'h00);
        wr(OFS_CTRL_B, 8'h01);
        repeat (20) @(negedge clk_in);
        rd(OFS_COUNT);
        cmp8("ctc wrap", 8'h03, q);
        tally_and_finish();
    end
endmodule : timer8_control_and_prescaler_sync_tb_top
